/* File: design/pdx_pkg.sv */
// constants and carrier types for the paged data address extender
// assumes the core data address generator and sfr writes run on MCLK
package pdx_pkg;
	localparam int RD_PAGE_W = 10;
	localparam int WR_PAGE_W = 9;
	localparam int EA_W      = 16;
	localparam int XA_W      = 24;
	localparam int EA_PAGE_BIT   = 15;
	localparam int RD_WINDOW_BIT = 9;
	localparam logic [RD_PAGE_W-1:0] RD_PAGE_RST = 10'h000;
	localparam logic [WR_PAGE_W-1:0] WR_PAGE_RST = 9'h000;
	localparam int XFER_LATENCY = 1;

	typedef enum logic {PDX_POST_MOD, PDX_PRE_MOD} pdx_mode_t;

	typedef struct packed {
		logic            valid;
		logic            write;
		pdx_mode_t       mode;
		logic [EA_W-1:0] ea;
	} pdx_req_t;

	typedef struct packed {
		logic            valid;
		logic            write;
		logic            paged;
		logic            program_space_window;
		logic [XA_W-1:0] addr;
	} pdx_rsp_t;

	typedef struct packed {
		logic                 wr_read_page;
		logic                 wr_write_page;
		logic [RD_PAGE_W-1:0] wdata;
	} pdx_sfr_t;
endpackage

/* File: design/pdx_extender.sv */
// paged data address extender: ea plus page registers to extended address
// assumes requests and sfr strobes come from core logic on MCLK
// Overview of operation
// RULE1: separate read page register of 10 bits and write page register of 9 bits
// RULE2: paging only applies when effective address bit 15 is set
// RULE3: read, page bit 9 clear, ea15 set: read page 8..0 above ea 14..0
// RULE4: write with ea15 set: write page 8..0 above ea 14..0
// RULE5: formation identical for pre-modified and post-modified effective addresses
// RULE6: page registers written and read back as ordinary sfr registers
// RULE7: ea15 clear: address passes through unpaged, page registers ignored
module pdx_extender
	import pdx_pkg::*;
#(
	parameter int RD_W = pdx_pkg::RD_PAGE_W,
	parameter int WR_W = pdx_pkg::WR_PAGE_W
)
(
	input  wire logic               MCLK,
	input  wire logic               RESET_N,
	input  wire pdx_pkg::pdx_sfr_t  SFR_IN,
	input  wire pdx_pkg::pdx_req_t  REQ,
	output      pdx_pkg::pdx_rsp_t  RSP,
	output      logic [RD_W-1:0]    DATA_READ_PAGE,
	output      logic [WR_W-1:0]    DATA_WRITE_PAGE
);
	import pdx_pkg::*;

	// elaboration check on the page widths
	if (RD_W != RD_PAGE_W || WR_W != WR_PAGE_W)
	begin : g_width_check
		$error("page widths must match the 24-bit address split");
	end

	logic [RD_W-1:0] data_read_page_q;
	logic [WR_W-1:0] data_write_page_q;
	pdx_rsp_t        rsp_q;
	pdx_rsp_t        rsp_d;
	logic            hi_half;
	logic [8:0]      rd_page_low;
	logic [8:0]      wr_page_low;
	logic            rd_window;
	logic [XA_W-1:0] pass_addr;
	logic [XA_W-1:0] rd_xaddr;
	logic [XA_W-1:0] wr_xaddr;

	// sfr side of the page registers
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			data_read_page_q <= RD_PAGE_RST;
		else if (SFR_IN.wr_read_page)
			data_read_page_q <= SFR_IN.wdata[RD_W-1:0]; // RULE1 RULE6
	end

	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			data_write_page_q <= WR_PAGE_RST;
		else if (SFR_IN.wr_write_page)
			data_write_page_q <= SFR_IN.wdata[WR_W-1:0]; // RULE1 RULE6
	end

	assign DATA_READ_PAGE  = data_read_page_q; // RULE6
	assign DATA_WRITE_PAGE = data_write_page_q;

	// address formation, mode deliberately not consulted
	assign hi_half = REQ.ea[EA_PAGE_BIT]; // RULE2 RULE5

	// candidate addresses, one per outcome
	assign rd_page_low = data_read_page_q[8:0];
	assign wr_page_low = data_write_page_q[8:0];
	assign rd_window   = data_read_page_q[RD_WINDOW_BIT];
	assign pass_addr   = {8'h00, REQ.ea}; // RULE7
	assign rd_xaddr    = {rd_page_low, REQ.ea[14:0]}; // RULE3
	assign wr_xaddr    = {wr_page_low, REQ.ea[14:0]}; // RULE4

	always_comb
	begin
		rsp_d                      = '0;
		rsp_d.valid                = REQ.valid;
		rsp_d.write                = REQ.write;
		rsp_d.addr                 = pass_addr; // RULE7
		if (hi_half)
		begin
			if (REQ.write)
			begin
				rsp_d.paged = 1'b1;
				rsp_d.addr  = wr_xaddr; // RULE4
			end
			else if (!rd_window)
			begin
				rsp_d.paged = 1'b1;
				rsp_d.addr  = rd_xaddr; // RULE3
			end
			else
				rsp_d.program_space_window = 1'b1;
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			rsp_q <= '0;
		else
			rsp_q <= rsp_d;
	end

	assign RSP = rsp_q;

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESET_N);

	a_read_page_load: assert property ( // RULE1
		SFR_IN.wr_read_page |=> DATA_READ_PAGE == $past(SFR_IN.wdata))
		else $error("read page not loaded");
	a_write_page_hold: assert property ( // RULE6
		!SFR_IN.wr_write_page |=> $stable(DATA_WRITE_PAGE))
		else $error("write page changed without write");
	a_unpaged_pass: assert property ( // RULE7
		REQ.valid && !REQ.ea[15] |=> RSP.valid && RSP.addr == {8'h00, $past(REQ.ea)} && !RSP.paged)
		else $error("low half access not passed through");
	a_paged_only_high: assert property ( // RULE2
		RSP.paged |-> $past(REQ.ea[15]))
		else $error("paging applied to low half");
	a_read_paged_addr: assert property ( // RULE3
		REQ.valid && !REQ.write && REQ.ea[15] && !DATA_READ_PAGE[9]
		|=> RSP.paged && RSP.addr == {$past(DATA_READ_PAGE[8:0]), $past(REQ.ea[14:0])})
		else $error("read extended address wrong");
	a_write_paged_addr: assert property ( // RULE4
		REQ.valid && REQ.write && REQ.ea[15]
		|=> RSP.paged && RSP.write && RSP.addr == {$past(DATA_WRITE_PAGE), $past(REQ.ea[14:0])})
		else $error("write extended address wrong");
	a_mode_blind_form: assert property ( // RULE5
		REQ.valid && REQ.mode == PDX_PRE_MOD && REQ.ea[15] && REQ.write
		|=> RSP.addr[14:0] == $past(REQ.ea[14:0]) && RSP.paged)
		else $error("pre-modified access not paged");
	a_window_flag: assert property ( // RULE3
		REQ.valid && !REQ.write && REQ.ea[15] && DATA_READ_PAGE[9]
		|=> RSP.program_space_window && !RSP.paged)
		else $error("window read not flagged");

	a_write_page_load: assert property ( // RULE1
		SFR_IN.wr_write_page
		|=> DATA_WRITE_PAGE == $past(SFR_IN.wdata[8:0]))
		else $error("write page not loaded");

	a_read_page_hold: assert property ( // RULE6
		!SFR_IN.wr_read_page
		|=> $stable(DATA_READ_PAGE))
		else $error("read page changed without write");

	a_both_strobes: assert property ( // RULE1
		SFR_IN.wr_read_page && SFR_IN.wr_write_page
		|=> DATA_READ_PAGE[8:0] == DATA_WRITE_PAGE)
		else $error("joint page write differs");

	a_rsp_valid_copy: assert property ( // RULE5
		REQ.valid
		|=> RSP.valid)
		else $error("response valid missing");

	a_rsp_idle_low: assert property ( // RULE5
		!REQ.valid
		|=> !RSP.valid)
		else $error("response valid without request");

	a_rsp_write_copy: assert property ( // RULE4
		REQ.valid
		|=> RSP.write == $past(REQ.write))
		else $error("response direction wrong");

	a_low_ignores_page: assert property ( // RULE7
		REQ.valid && !REQ.ea[15]
		|=> !RSP.program_space_window && RSP.addr[23:16] == 8'h00)
		else $error("low half access used a page");

	a_low_read_unpaged: assert property ( // RULE7
		REQ.valid && !REQ.write && !REQ.ea[15]
		|=> !RSP.paged && !RSP.write)
		else $error("low half read paged");

	a_low_write_unpaged: assert property ( // RULE7
		REQ.valid && REQ.write && !REQ.ea[15]
		|=> !RSP.paged && RSP.write && RSP.addr == {8'h00, $past(REQ.ea)})
		else $error("low half write paged");

	a_window_pass_addr: assert property ( // RULE3
		REQ.valid && !REQ.write && REQ.ea[15] && DATA_READ_PAGE[9]
		|=> RSP.addr == {8'h00, $past(REQ.ea)})
		else $error("window read address wrong");

	a_post_mod_form: assert property ( // RULE5
		REQ.valid && REQ.mode == PDX_POST_MOD && REQ.ea[15] && REQ.write
		|=> RSP.paged && RSP.addr[14:0] == $past(REQ.ea[14:0]))
		else $error("post-modified access not paged");

	a_read_mod_blind: assert property ( // RULE5
		REQ.valid && !REQ.write && REQ.ea[15] && !DATA_READ_PAGE[9]
		|=> RSP.addr[14:0] == $past(REQ.ea[14:0]))
		else $error("read offset altered");

	a_read_top_bits: assert property ( // RULE3
		REQ.valid && !REQ.write && REQ.ea[15] && !DATA_READ_PAGE[9]
		|=> RSP.addr[23:15] == $past(DATA_READ_PAGE[8:0]))
		else $error("read page bits misplaced");

	a_write_no_window: assert property ( // RULE4
		REQ.valid && REQ.write
		|=> !RSP.program_space_window)
		else $error("write flagged as window");

	a_paged_excl_window: assert property ( // RULE3
		RSP.paged
		|-> !RSP.program_space_window)
		else $error("paged and window together");

	c_paged_read:  cover property (REQ.valid && !REQ.write && REQ.ea[15] ##1 RSP.paged);
	c_paged_write: cover property (REQ.valid && REQ.write && REQ.ea[15] ##1 RSP.paged);
	c_pre_mod:     cover property (REQ.valid && REQ.mode == PDX_PRE_MOD ##1 RSP.valid);
	c_page_update: cover property (SFR_IN.wr_write_page ##1 REQ.valid && REQ.write);
	c_window_read: cover property (REQ.valid && !REQ.write ##1 RSP.program_space_window);
endmodule

/* File: test/pdx_core_model.sv */
// core-side model: issues one-cycle data move requests
// assumes MCLK comes from the bench
module pdx_core_model
	import pdx_pkg::*;
(
	input  wire logic        MCLK,
	output pdx_pkg::pdx_req_t REQ
);
	timeunit 1ns;
	timeprecision 1ns;
	initial REQ = '0;
	task automatic issue(input logic wr, input pdx_mode_t md, input logic [15:0] ea);
	begin
		@(posedge MCLK);
		REQ <= '{1'b1, wr, md, ea};
		@(posedge MCLK);
		REQ <= '{1'b0, ~wr, md, ~ea};
	end
	endtask
endmodule

/* File: test/paged_data_address_extender_tb_top.sv */
// bench for the paged data address extender
// assumes the core model drives requests and the bench drives sfr strobes
module paged_data_address_extender_tb_top
	import pdx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
		$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
	logic       MCLK = 0;
	logic       RESET_N = 0;
	pdx_sfr_t   sfr = '0;
	pdx_req_t   req;
	pdx_rsp_t   rsp;
	logic [9:0] rdp;
	logic [8:0] wrp;
	int         n_fail = 0;
	int         checks_done = 0;
	always #25 MCLK = ~MCLK;
	pdx_core_model core (.MCLK(MCLK), .REQ(req));
	pdx_extender dut (.MCLK(MCLK), .RESET_N(RESET_N), .SFR_IN(sfr), .REQ(req), .RSP(rsp),
		.DATA_READ_PAGE(rdp), .DATA_WRITE_PAGE(wrp));
	task automatic results;
	begin
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask
	task automatic set_pages(input logic rd, input logic wr, input logic [9:0] d);
	begin
		@(posedge MCLK);
		sfr <= '{rd, wr, d};
		@(posedge MCLK);
		sfr <= '0;
		#1;
	end
	endtask
	task automatic t_pages;
	begin
		@(negedge MCLK);
		`CHK("pages reset", 19'h0_0000, {rdp, wrp})
		`CHK("rsp reset", 28'h000_0000, rsp)
		set_pages(1, 1, 10'h3ff);
		`CHK("both pages", {10'h3ff, 9'h1ff}, {rdp, wrp})
		set_pages(1, 0, 10'h155);
		set_pages(0, 1, 10'h0aa);
		`CHK("pages kept", {10'h155, 9'h0aa}, {rdp, wrp})
		$display("test pages done");
	end
	endtask
	task automatic t_paging;
		logic [15:0] ea;
		logic [23:0] xa;
	begin
		for (int i = 0; i < 8; i++)
		begin
			ea = {i[0], 15'(16'h7ff0 + i)};
			xa = ea[15] ? {(i[1] ? 9'h0aa : 9'h155), ea[14:0]} : {8'h00, ea};
			core.issue(i[1], pdx_mode_t'(i[2]), ea);
			#1;
			`CHK("rsp kind", {1'b1, i[1], ea[15]}, {rsp.valid, rsp.write, rsp.paged})
			`CHK("no window", 1'b0, rsp.program_space_window)
			if (!ea[15])
				`CHK("low addr", xa, rsp.addr)
			else if (i[1])
				`CHK("write addr", xa, rsp.addr)
			else
				`CHK("read addr", xa, rsp.addr)
			`CHK("mode blind", xa, rsp.addr)
		end
		$display("test paging done");
	end
	endtask
	task automatic t_window;
	begin
		set_pages(1, 0, 10'h2aa);
		core.issue(0, PDX_POST_MOD, 16'h8123);
		#1;
		`CHK("window kind", 3'b101, {rsp.valid, rsp.paged, rsp.program_space_window})
		`CHK("window addr", 24'h00_8123, rsp.addr)
		core.issue(1, PDX_PRE_MOD, 16'hc001);
		#1;
		`CHK("write beside window", 24'h55_4001, rsp.addr)
		@(posedge MCLK);
		#1;
		`CHK("rsp idle", 1'b0, rsp.valid)
		$display("test window done");
	end
	endtask
	initial
	begin
		repeat (2000) @(posedge MCLK);
		n_fail++;
		results;
	end
	initial
	begin
		repeat (20) @(posedge MCLK);
		RESET_N <= 1'b1;
		t_pages;
		t_paging;
		t_window;
		results;
	end
endmodule
